/* mlf_pkg.sv */
// Purpose: Constants and carrier types for the motor lock and fault supervisor.
// Assumes: Measurements arrive as unsigned codes on the mclk domain.
// Notes: Scales are integer codes; see module parameters for the step sizes.
// Notes on behaviour
// - Cap amplitude at limit times resistance plus back-EMF
// - Cap uses programmed parameters, never measured current
// - Cap only in closed loop, never faults
// - Fixed short-circuit trip stops drive, enters lock
// - Low-side current over selected threshold trips lock
// - Six enable bits gate each scheme individually
// - Six flags record detections, even when disabled
// - Flags clear automatically on motor restart
// - Lock forces high impedance through surge sequence
// - Wait retry delay, then restart the motor
// - Speed-based back-EMF above amplitude for filter time
// - Measured velocity constant outside window for filter time
// - No motor if phase current not above 140 mA
// - Open loop: no back-EMF one cycle after handoff
// - Closed loop: period over twice previous period
// - Surge: high sides off, low sides after delay
package mlf_pkg;
    localparam int          CLK_MHZ          = 200;
    localparam int          NO_MOTOR_MA      = 140;
    localparam int          FLAG_CURRENT     = 0;
    localparam int          FLAG_SPEED       = 1;
    localparam int          FLAG_KCONST      = 2;
    localparam int          FLAG_NO_MOTOR    = 3;
    localparam int          FLAG_OL_STUCK    = 4;
    localparam int          FLAG_CL_STUCK    = 5;
    localparam logic [5:0]  FLAGS_RESET      = 6'h00;
    localparam logic [8:0]  AMP_RESET        = 9'h000;
    localparam logic [8:0]  AMP_MAX          = 9'h1ff;

    typedef enum logic [1:0] {
        MLF_RUN     = 2'b00,
        MLF_BRAKE   = 2'b01,
        MLF_OFF     = 2'b11,
        MLF_RESTART = 2'b10
    } mlf_state_t;

    typedef struct packed {
        logic        closed_loop;
        logic        accelerating;
        logic        handoff_passed;
        logic        drive_cycle;
        logic        bemf_zc;
        logic        commutate;
        logic [11:0] speed;
        logic [11:0] phase_u_ma;
        logic [11:0] lowside_ma;
        logic [10:0] kconst_meas;
        logic [8:0]  speed_cmd;
    } mlf_meas_t;

    typedef struct packed {
        logic        hs_enable;
        logic        ls_enable;
        logic        outputs_hiz;
        logic        lock_detected;
        logic        motor_restart;
        logic        overcurrent_flag;
        logic        accel_cap_active;
        logic [8:0]  drive_amplitude;
    } mlf_drive_t;
endpackage

/* mlf_motor_lock.sv */
// Purpose: Acceleration cap, lock detection, surge-safe shutdown and retry.
// Assumes: Measurement struct is on mclk; short_circuit_pin is asynchronous.
// Notes: One state struct, one comb fill, one register.
module mlf_motor_lock
    import mlf_pkg::*;
#(
    parameter int ILIMIT_STEP_MA     = 100,
    parameter int LOCK_STEP_MA       = 250,
    parameter int CAP_SHIFT          = 8,
    parameter int BRAKE_STEP_CYCLES  = 200,
    parameter int LOCK_FILTER_CYCLES = 20000,
    parameter int RETRY_CYCLES       = 1000000
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire mlf_meas_t  meas,
    input  wire logic       short_circuit_pin,
    input  wire logic [3:0] accel_current_limit_sel,
    input  wire logic [2:0] lock_current_limit_sel,
    input  wire logic [5:0] lock_scheme_enable,
    input  wire logic [6:0] winding_resistance_setting,
    input  wire logic [6:0] velocity_constant_setting,
    input  wire logic [1:0] kconst_window_sel,
    input  wire logic [2:0] brake_delay_sel,
    input  wire logic       surge_protection,
    output mlf_drive_t      drive,
    output logic [5:0]      fault_flags
);
    // Elaboration checks: timers are 24 bits, current codes 12 bits
    if (RETRY_CYCLES < 1 || RETRY_CYCLES > 16777215
        || LOCK_FILTER_CYCLES < 1 || LOCK_FILTER_CYCLES > 16777215) begin
        $error("mlf_motor_lock: timing count out of range");
    end
    if (BRAKE_STEP_CYCLES < 1 || BRAKE_STEP_CYCLES > 65535
        || CAP_SHIFT < 0 || CAP_SHIFT > 15) begin
        $error("mlf_motor_lock: brake step or cap shift out of range");
    end
    if (ILIMIT_STEP_MA < 1 || ILIMIT_STEP_MA > 255
        || LOCK_STEP_MA < 1 || LOCK_STEP_MA > 511) begin
        $error("mlf_motor_lock: current step out of range");
    end

    typedef struct packed {
        mlf_state_t  state;
        logic [23:0] timer;
        logic [23:0] speed_filt;
        logic [23:0] kconst_filt;
        logic [19:0] period_cnt;
        logic [19:0] period_prev;
        logic        ol_armed;
        logic        ol_seen_zc;
        logic        was_closed;
        logic [1:0]  sc_sync;
        logic [5:0]  flags;
        mlf_drive_t  out;
    } mlf_st_t;

    mlf_st_t st_reg;
    mlf_st_t st_next;

    logic [11:0] ilimit_ma;
    logic [11:0] lock_ma;
    logic [10:0] res_val;
    logic [10:0] vconst_val;
    logic [24:0] ulimit_raw;
    logic [24:0] bemf_raw;
    logic [8:0]  ulimit;
    logic [8:0]  bemf_speed;
    logic [10:0] vconst_margin;
    logic [11:0] vconst_high;
    logic [11:0] vconst_low;
    logic [5:0]  detect;
    logic        lock_cond;
    logic [23:0] brake_cycles;

    always_comb begin
        ilimit_ma  = 12'((32'(accel_current_limit_sel) + 32'd1) * ILIMIT_STEP_MA);
        lock_ma    = 12'((32'(lock_current_limit_sel) + 32'd1) * LOCK_STEP_MA);
        res_val    = 11'(winding_resistance_setting[3:0]) << winding_resistance_setting[6:4];
        vconst_val = 11'(velocity_constant_setting[3:0]) << velocity_constant_setting[6:4];
        // Programmed resistance and constant only, no measured current
        ulimit_raw = (25'(ilimit_ma) * 25'(res_val) + 25'(meas.speed) * 25'(vconst_val))
                     >> CAP_SHIFT;
        bemf_raw   = (25'(meas.speed) * 25'(vconst_val)) >> CAP_SHIFT;
        ulimit     = (ulimit_raw > 25'(AMP_MAX)) ? AMP_MAX : ulimit_raw[8:0];
        bemf_speed = (bemf_raw > 25'(AMP_MAX)) ? AMP_MAX : bemf_raw[8:0];
        vconst_margin = vconst_val >> (3'd1 + 3'(kconst_window_sel));
        vconst_high   = 12'(vconst_val) + 12'(vconst_margin);
        vconst_low    = 12'(vconst_val) - 12'(vconst_margin);
        brake_cycles = 24'(32'(brake_delay_sel) * BRAKE_STEP_CYCLES);
    end

    always_comb begin
        st_next = st_reg;
        st_next.out.motor_restart = 1'b0;
        st_next.sc_sync = {st_reg.sc_sync[0], short_circuit_pin};
        st_next.was_closed = meas.closed_loop;
        detect = 6'h00;

        if (st_reg.state == MLF_RUN) begin
            detect[FLAG_CURRENT] = meas.lowside_ma > lock_ma;
            // Filtered speed-based back-EMF versus applied amplitude
            if (meas.closed_loop && bemf_speed > st_reg.out.drive_amplitude) begin
                if (st_reg.speed_filt < 24'(LOCK_FILTER_CYCLES))
                    st_next.speed_filt = st_reg.speed_filt + 24'd1;
            end else begin
                st_next.speed_filt = '0;
            end
            detect[FLAG_SPEED] = st_reg.speed_filt >= 24'(LOCK_FILTER_CYCLES);
            if (meas.closed_loop && (12'(meas.kconst_meas) > vconst_high
                                     || 12'(meas.kconst_meas) < vconst_low)) begin
                if (st_reg.kconst_filt < 24'(LOCK_FILTER_CYCLES))
                    st_next.kconst_filt = st_reg.kconst_filt + 24'd1;
            end else begin
                st_next.kconst_filt = '0;
            end
            detect[FLAG_KCONST] = st_reg.kconst_filt >= 24'(LOCK_FILTER_CYCLES);
            detect[FLAG_NO_MOTOR] = meas.closed_loop && !st_reg.was_closed
                                    && meas.phase_u_ma <= 12'(NO_MOTOR_MA);
            // Open loop: a drive cycle passing with no zero cross is a stall
            if (meas.closed_loop || !meas.handoff_passed) begin
                st_next.ol_armed = 1'b0;
            end else if (meas.drive_cycle) begin
                detect[FLAG_OL_STUCK] = st_reg.ol_armed && !st_reg.ol_seen_zc
                                        && !meas.bemf_zc;
                st_next.ol_armed   = 1'b1;
                st_next.ol_seen_zc = 1'b0;
            end else if (meas.bemf_zc) begin
                st_next.ol_seen_zc = 1'b1;
            end
            // Closed loop: commutation period against the previous one
            if (!meas.closed_loop) begin
                st_next.period_cnt  = '0;
                st_next.period_prev = '0;
            end else if (meas.commutate) begin
                st_next.period_prev = st_reg.period_cnt;
                st_next.period_cnt  = '0;
            end else if (st_reg.period_cnt != '1) begin
                st_next.period_cnt = st_reg.period_cnt + 20'd1;
            end
            detect[FLAG_CL_STUCK] = meas.closed_loop && st_reg.period_prev != '0
                && 21'(st_reg.period_cnt) > (21'(st_reg.period_prev) << 1);
        end

        lock_cond = |(detect & lock_scheme_enable) || st_reg.sc_sync[1];

        // Acceleration cap in closed loop only; it never raises a fault
        st_next.out.accel_cap_active = meas.closed_loop && meas.accelerating
                                       && meas.speed_cmd > ulimit;
        st_next.out.drive_amplitude = st_next.out.accel_cap_active ? ulimit
                                                                   : meas.speed_cmd;

        case (st_reg.state)
            MLF_RUN: begin
                if (lock_cond) begin
                    st_next.out.lock_detected    = 1'b1;
                    st_next.out.overcurrent_flag = st_reg.sc_sync[1] | st_reg.out.overcurrent_flag;
                    st_next.out.hs_enable        = 1'b0;
                    st_next.out.outputs_hiz      = 1'b1;
                    st_next.timer                = brake_cycles;
                    if (surge_protection && brake_delay_sel != 3'h0) begin
                        st_next.state = MLF_BRAKE;
                    end else begin
                        st_next.out.ls_enable = 1'b0;
                        st_next.timer         = 24'(RETRY_CYCLES);
                        st_next.state         = MLF_OFF;
                    end
                end
            end
            MLF_BRAKE: begin
                if (st_reg.timer <= 24'd1) begin
                    st_next.out.ls_enable = 1'b0;
                    st_next.timer         = 24'(RETRY_CYCLES);
                    st_next.state         = MLF_OFF;
                end else begin
                    st_next.timer = st_reg.timer - 24'd1;
                end
            end
            MLF_OFF: begin
                if (st_reg.timer <= 24'd1) begin
                    st_next.state = MLF_RESTART;
                end else begin
                    st_next.timer = st_reg.timer - 24'd1;
                end
            end
            MLF_RESTART: begin
                st_next.out.motor_restart    = 1'b1;
                st_next.out.hs_enable        = 1'b1;
                st_next.out.ls_enable        = 1'b1;
                st_next.out.outputs_hiz      = 1'b0;
                st_next.out.lock_detected    = 1'b0;
                st_next.out.overcurrent_flag = 1'b0;
                st_next.speed_filt  = '0;
                st_next.kconst_filt = '0;
                st_next.ol_armed    = 1'b0;
                // Stale periods would re-trip the stuck check at once
                st_next.ol_seen_zc  = 1'b0;
                st_next.period_cnt  = '0;
                st_next.period_prev = '0;
                st_next.state       = MLF_RUN;
            end
            default: st_next.state = MLF_OFF;
        endcase

        // Restart clears flags; detect is zero in that cycle, as it is only set in MLF_RUN
        st_next.flags = (st_reg.state == MLF_RESTART ? FLAGS_RESET : st_reg.flags) | detect;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_reg             <= '0;
            st_reg.state       <= MLF_RUN;
            st_reg.flags       <= FLAGS_RESET;
            st_reg.out.hs_enable <= 1'b1;
            st_reg.out.ls_enable <= 1'b1;
            st_reg.out.drive_amplitude <= AMP_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign drive       = st_reg.out;
    assign fault_flags = st_reg.flags;
endmodule

/* mlf_bridge_model.sv */
// Purpose: Power bridge and motor stand-in for the lock supervisor.
// Assumes: Load current flows only while the low-side drivers conduct.
// Notes: A short draws through the high side, so it ends once that side opens.
module mlf_bridge_model
    import mlf_pkg::*;
(
    input  wire logic        mclk,
    input  wire mlf_drive_t  drive,
    input  wire logic [11:0] load_ma,
    input  wire logic        short_req,
    output logic [11:0]      lowside_ma,
    output logic             short_circuit_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge mclk) begin
        lowside_ma        <= drive.ls_enable ? load_ma : 12'h000;
        short_circuit_pin <= short_req && drive.hs_enable;
    end
endmodule

/* mlf_motor_lock_props.sv */
// Purpose: Port-level checks of the lock supervisor.
// Assumes: Outputs free of hiz, lock and restart mean the monitor runs.
// Notes: Counters track hiz and low-side-off spans.
module mlf_motor_lock_props
    import mlf_pkg::*;
#(
    parameter int ILIMIT_STEP_MA    = 100,
    parameter int LOCK_STEP_MA      = 250,
    parameter int CAP_SHIFT         = 8,
    parameter int BRAKE_STEP_CYCLES = 200,
    parameter int RETRY_CYCLES      = 1000000
) (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire mlf_meas_t  meas,
    input wire logic       short_circuit_pin,
    input wire logic [3:0] accel_current_limit_sel,
    input wire logic [2:0] lock_current_limit_sel,
    input wire logic [5:0] lock_scheme_enable,
    input wire logic [6:0] winding_resistance_setting,
    input wire logic [6:0] velocity_constant_setting,
    input wire logic [2:0] brake_delay_sel,
    input wire logic       surge_protection,
    input wire mlf_drive_t drive,
    input wire logic [5:0] fault_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    int   hiz_cnt;
    int   off_cnt;
    int   ulim;
    logic run;
    assign run = !drive.outputs_hiz && !drive.lock_detected && !drive.motor_restart;
    always_comb begin
        ulim = ((int'(accel_current_limit_sel) + 1) * ILIMIT_STEP_MA
               * (int'(winding_resistance_setting[3:0]) << winding_resistance_setting[6:4])
               + int'(meas.speed) * (int'(velocity_constant_setting[3:0])
               << velocity_constant_setting[6:4])) >> CAP_SHIFT;
        if (ulim > 511) ulim = 511;
    end
    always_ff @(posedge mclk) begin
        hiz_cnt <= (reset_n && drive.outputs_hiz) ? hiz_cnt + 1 : 0;
        off_cnt <= (reset_n && !drive.ls_enable) ? off_cnt + 1 : 0;
    end
    sequence s_trip;
        run && lock_scheme_enable[0]
            && meas.lowside_ma > (lock_current_limit_sel + 1) * LOCK_STEP_MA;
    endsequence
    sequence s_sc_held;
        short_circuit_pin && run ##1 short_circuit_pin [*2];
    endsequence
    a_trip_lock: assert property (s_trip |=> fault_flags[0] && drive.lock_detected)
        else $error("current trip not reported");
    a_short_stop: assert property (s_sc_held |-> ##[0:2] drive.overcurrent_flag
        && drive.outputs_hiz)
        else $error("short circuit not shut down");
    a_hiz_hs_off: assert property (drive.outputs_hiz |-> !drive.hs_enable)
        else $error("high side on in hiz");
    a_ls_nobrake: assert property ($rose(drive.outputs_hiz)
        && (!surge_protection || brake_delay_sel == 3'h0) |-> !drive.ls_enable)
        else $error("low side not off at once");
    a_ls_delay: assert property ($fell(drive.ls_enable) && surge_protection
        && brake_delay_sel != 3'h0 |-> hiz_cnt == brake_delay_sel * BRAKE_STEP_CYCLES)
        else $error("brake delay wrong");
    a_retry_wait: assert property (drive.motor_restart
        |-> off_cnt >= RETRY_CYCLES - 1 && off_cnt <= RETRY_CYCLES + 2)
        else $error("retry interval wrong");
    a_restart_clear: assert property (drive.motor_restart
        |-> fault_flags == FLAGS_RESET && !drive.lock_detected && !drive.outputs_hiz)
        else $error("restart did not clear");
    a_lock_holds: assert property ($past(drive.lock_detected) && !drive.motor_restart
        |-> drive.lock_detected)
        else $error("lock dropped early");
    a_flags_hold: assert property (!drive.motor_restart
        |-> (fault_flags & $past(fault_flags)) == $past(fault_flags))
        else $error("flag lost before restart");
    a_cap_value: assert property (drive.accel_cap_active
        |-> $past(meas.closed_loop && meas.accelerating)
        && drive.drive_amplitude == $past(ulim[8:0]))
        else $error("cap amplitude wrong");
    a_no_motor: assert property (run && $rose(meas.closed_loop)
        && meas.phase_u_ma <= NO_MOTOR_MA |=> fault_flags[FLAG_NO_MOTOR])
        else $error("no-motor not flagged");
endmodule
bind mlf_motor_lock mlf_motor_lock_props #(
    .ILIMIT_STEP_MA(ILIMIT_STEP_MA), .LOCK_STEP_MA(LOCK_STEP_MA), .CAP_SHIFT(CAP_SHIFT),
    .BRAKE_STEP_CYCLES(BRAKE_STEP_CYCLES), .RETRY_CYCLES(RETRY_CYCLES)
) mlf_motor_lock_props_i (
    .mclk(mclk), .reset_n(reset_n), .meas(meas), .short_circuit_pin(short_circuit_pin),
    .accel_current_limit_sel(accel_current_limit_sel),
    .lock_current_limit_sel(lock_current_limit_sel), .lock_scheme_enable(lock_scheme_enable),
    .winding_resistance_setting(winding_resistance_setting),
    .velocity_constant_setting(velocity_constant_setting), .brake_delay_sel(brake_delay_sel),
    .surge_protection(surge_protection), .drive(drive), .fault_flags(fault_flags)
);

/* testbench.sv */
// Purpose: Self-checking bench for the motor lock supervisor.
// Assumes: Short counts: filter 8, retry 20, brake step 3 cycles; resistance 30, constant 15.
// Notes: The bridge model turns drive outputs back into low-side current.
module testbench
    import mlf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk    = 1'b0;
    logic        reset_n = 1'b0;
    logic        sc_req  = 1'b0;
    logic        surge   = 1'b1;
    logic [3:0]  acc_sel = 4'h0;
    logic [11:0] load_ma = 12'h000;
    logic [5:0]  en      = 6'h3f;
    logic [2:0]  lock_sel = 3'h0;
    logic [1:0]  kwin     = 2'h0;
    logic [2:0]  brake    = 3'h1;
    mlf_meas_t   base    = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000, 12'h1f4, 12'h000,
                             11'h00f, 9'h000};
    mlf_meas_t   m       = '0;
    mlf_meas_t   mi;
    mlf_drive_t  drv;
    logic [5:0]  flags;
    logic [11:0] ls_ma;
    logic        sc_pin;
    int          n_errors     = 0;
    int          total_checks = 0;
    always_comb begin
        mi            = m;
        mi.lowside_ma = ls_ma;
    end
    initial forever #2.5 mclk = ~mclk;
    mlf_motor_lock #(.BRAKE_STEP_CYCLES(3), .LOCK_FILTER_CYCLES(8), .RETRY_CYCLES(20))
    mlf_motor_lock_i (
        .mclk(mclk), .reset_n(reset_n), .meas(mi), .short_circuit_pin(sc_pin),
        .accel_current_limit_sel(acc_sel), .lock_current_limit_sel(lock_sel),
        .lock_scheme_enable(en), .winding_resistance_setting(7'h1f),
        .velocity_constant_setting(7'h0f), .kconst_window_sel(kwin), .brake_delay_sel(brake),
        .surge_protection(surge), .drive(drv), .fault_flags(flags)
    );
    mlf_bridge_model mlf_bridge_model_i (
        .mclk(mclk), .drive(drv), .load_ma(load_ma), .short_req(sc_req),
        .lowside_ma(ls_ma), .short_circuit_pin(sc_pin)
    );
    task give_verdict();
        if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t flag %b, want %b", $time, got, exp);
        end
    endtask
    task chk_val(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t value %h, want %h", $time, got, exp);
        end
    endtask
    task do_reset(input int n);
        @(posedge mclk);
        reset_n <= 1'b0;
        m       <= base;
        load_ma <= 12'h000;
        sc_req  <= 1'b0;
        en      <= 6'h3f;
        surge   <= 1'b1;
        repeat (n) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
    endtask
    task trip(input int idx, input int lo, input int lim);
        int i;
        i = 0;
        while (drv.lock_detected !== 1'b1 && i < lim) begin
            @(negedge mclk);
            i++;
        end
        chk_bit(i >= lo && i < lim, 1'b1);
        chk_val({3'h0, flags}, 9'h001 << idx);
        chk_bit(drv.outputs_hiz, 1'b1);
        @(posedge mclk);
        m       <= base;
        load_ma <= 12'h000;
        i = 0;
        while (drv.motor_restart !== 1'b1 && i < 80) begin
            @(negedge mclk);
            i++;
        end
        chk_bit(drv.motor_restart, 1'b1);
        chk_val({3'h0, flags}, 9'h000);
        chk_bit(drv.hs_enable, 1'b1);
        repeat (3) @(negedge mclk);
        chk_bit(drv.lock_detected, 1'b0);
    endtask
    initial begin
        #50000;
        n_errors++;
        give_verdict();
    end
    initial begin
        do_reset(8);
        chk_val({3'h0, flags}, 9'h000);
        chk_bit(drv.outputs_hiz, 1'b0);
        repeat (2) begin
            repeat (10) @(posedge mclk);
            m.commutate <= 1'b1;
            @(posedge mclk);
            m.commutate <= 1'b0;
        end
        trip(FLAG_CL_STUCK, 18, 40);
        do_reset(2);
        @(posedge mclk);
        load_ma  <= 12'h12c;
        lock_sel <= 3'h1;
        repeat (4) @(negedge mclk);
        chk_val({3'h0, flags}, 9'h000);
        @(posedge mclk);
        lock_sel <= 3'h0;
        trip(FLAG_CURRENT, 0, 10);
        @(posedge mclk);
        m.accelerating <= 1'b1;
        m.speed_cmd    <= 9'h1ff;
        m.speed        <= 12'h064;
        for (int s = 0; s < 16; s++) begin
            @(posedge mclk);
            acc_sel <= 4'(s);
            repeat (3) @(negedge mclk);
            chk_val(drv.drive_amplitude, 9'(((s + 1) * 3000 + 1500) >> 8));
            chk_bit(drv.accel_cap_active, 1'b1);
        end
        @(posedge mclk);
        m.phase_u_ma <= 12'hfff;
        repeat (3) @(negedge mclk);
        chk_val(drv.drive_amplitude, 9'h0c1);
        chk_bit(drv.lock_detected, 1'b0);
        @(posedge mclk);
        m.closed_loop <= 1'b0;
        repeat (3) @(negedge mclk);
        chk_bit(drv.accel_cap_active, 1'b0);
        @(posedge mclk);
        m       <= base;
        acc_sel <= 4'h0;
        @(posedge mclk);
        m.speed <= 12'h064;
        trip(FLAG_SPEED, 8, 16);
        @(posedge mclk);
        kwin          <= 2'h3;
        brake         <= 3'h2;
        m.kconst_meas <= 11'h00e;
        trip(FLAG_KCONST, 8, 16);
        @(posedge mclk);
        m.closed_loop    <= 1'b0;
        m.handoff_passed <= 1'b1;
        repeat (2) begin
            @(posedge mclk);
            m.drive_cycle <= 1'b1;
            @(posedge mclk);
            m.drive_cycle <= 1'b0;
        end
        trip(FLAG_OL_STUCK, 0, 6);
        @(posedge mclk);
        m.closed_loop <= 1'b0;
        m.phase_u_ma  <= 12'h08d;
        @(posedge mclk);
        m.closed_loop <= 1'b1;
        repeat (4) @(negedge mclk);
        chk_val({3'h0, flags}, 9'h000);
        @(posedge mclk);
        m.closed_loop <= 1'b0;
        m.phase_u_ma  <= 12'h08c;
        @(posedge mclk);
        m.closed_loop <= 1'b1;
        trip(FLAG_NO_MOTOR, 0, 6);
        @(posedge mclk);
        en      <= 6'h3e;
        load_ma <= 12'h12c;
        repeat (8) @(negedge mclk);
        chk_val({3'h0, flags}, 9'h001);
        chk_bit(drv.lock_detected, 1'b0);
        do_reset(2);
        @(posedge mclk);
        en     <= 6'h00;
        surge  <= 1'b0;
        sc_req <= 1'b1;
        repeat (8) @(negedge mclk);
        chk_bit(drv.overcurrent_flag, 1'b1);
        chk_bit(drv.ls_enable, 1'b0);
        do_reset(2);
        give_verdict();
    end
endmodule
